// File: wfd_wake_frame_detect.sv
// wfd_wake_frame_detect.sv: receive-side wake frame detector with axi4-lite registers
`timescale 1ns/1ps
module wfd_wake_frame_detect (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // receive byte stream from the pcs, same clock
  input wire logic rx_sof,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_eof,
  // axi4-lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // notification
  output logic wake_pin,
  output logic wake_irq
);
  import wfd_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [WFD_CFG_W-1:0] wake_config_reg;
  logic [WFD_ST_W-1:0] wake_status_reg;
  logic int_flag;
  logic int_en;
  logic [47:0] station_addr;
  logic [47:0] password;
  logic [6:0] pat_len;

  // ---------------------------------------------------------------
  // axi write channel
  // ---------------------------------------------------------------
  logic [11:0] aw_addr;
  logic aw_have;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_have;
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire wr_cfg = do_write && aw_addr == WFD_ADDR_CFG;
  wire wr_stat = do_write && aw_addr == WFD_ADDR_STAT;
  wire wr_int = do_write && aw_addr == WFD_ADDR_INT;
  wire wr_mac_lo = do_write && aw_addr == WFD_ADDR_MAC_LO;
  wire wr_mac_hi = do_write && aw_addr == WFD_ADDR_MAC_HI;
  wire wr_pw_lo = do_write && aw_addr == WFD_ADDR_PW_LO;
  wire wr_pw_hi = do_write && aw_addr == WFD_ADDR_PW_HI;
  wire wr_pat_en = do_write && aw_addr == WFD_ADDR_PAT_EN;
  wire wr_pat = do_write && aw_addr[11:6] == WFD_ADDR_PAT_BASE[11:6] && aw_addr[1:0] == 2'h0;
  wire wr_hit = wr_cfg || wr_stat || wr_int || wr_mac_lo || wr_mac_hi || wr_pw_lo || wr_pw_hi || wr_pat_en || wr_pat;
  // ready leaves a flop, so it is worked out from the next state of the beat holders
  wire next_aw_have = !do_write && (aw_have || (s_axi_awvalid && s_axi_awready));
  wire next_w_have = !do_write && (w_have || (s_axi_wvalid && s_axi_wready));
  wire next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);

  // address and data captured in either order, one transfer at a time
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= WFD_RESP_OK;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_awready <= !next_aw_have && !next_bvalid;
      s_axi_wready <= !next_w_have && !next_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? WFD_RESP_OK : WFD_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // byte-lane merge used by the config, address, password and pattern length words
  function automatic logic [31:0] wfd_merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : wfd_merge

  wire [31:0] m_cfg = wfd_merge({27'h0, wake_config_reg}, w_data, w_strb);
  wire [31:0] m_mac_lo = wfd_merge(station_addr[31:0], w_data, w_strb);
  wire [31:0] m_mac_hi = wfd_merge({16'h0, station_addr[47:32]}, w_data, w_strb);
  wire [31:0] m_pw_lo = wfd_merge(password[31:0], w_data, w_strb);
  wire [31:0] m_pw_hi = wfd_merge({16'h0, password[47:32]}, w_data, w_strb);
  wire [31:0] m_pat_en = wfd_merge({25'h0, pat_len}, w_data, w_strb);

  // configuration storage
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wake_config_reg <= WFD_CFG_RST;
      station_addr <= 48'h000000000000;
      password <= 48'h000000000000;
      pat_len <= 7'h00;
      int_en <= 1'b0;
    end else begin
      if (wr_cfg) wake_config_reg <= m_cfg[WFD_CFG_W-1:0];
      if (wr_mac_lo) station_addr[31:0] <= m_mac_lo;
      if (wr_mac_hi) station_addr[47:32] <= m_mac_hi[15:0];
      if (wr_pw_lo) password[31:0] <= m_pw_lo;
      if (wr_pw_hi) password[47:32] <= m_pw_hi[15:0];
      if (wr_pat_en) pat_len <= (m_pat_en[6:0] > 7'd64) ? 7'd64 : m_pat_en[6:0];
      if (wr_int && w_strb[0]) int_en <= w_data[WFD_INT_EN];
    end
  end

  // ---------------------------------------------------------------
  // axi read channel
  // ---------------------------------------------------------------
  logic [11:0] rd_addr;
  logic rd_pend;
  logic [31:0] pat_word;
  wire rd_is_pat = rd_addr[11:6] == WFD_ADDR_PAT_BASE[11:6] && rd_addr[1:0] == 2'h0;
  logic [31:0] rd_mux;
  logic rd_ok;
  // pattern words come from the memory register, loaded at the edge that takes the address
  always_comb begin
    rd_ok = 1'b1;
    if (rd_addr == WFD_ADDR_CFG) rd_mux = {27'h0, wake_config_reg};
    else if (rd_addr == WFD_ADDR_STAT) rd_mux = {28'h0, wake_status_reg};
    else if (rd_addr == WFD_ADDR_INT) rd_mux = {30'h0, int_en, int_flag};
    else if (rd_addr == WFD_ADDR_MAC_LO) rd_mux = station_addr[31:0];
    else if (rd_addr == WFD_ADDR_MAC_HI) rd_mux = {16'h0, station_addr[47:32]};
    else if (rd_addr == WFD_ADDR_PW_LO) rd_mux = password[31:0];
    else if (rd_addr == WFD_ADDR_PW_HI) rd_mux = {16'h0, password[47:32]};
    else if (rd_addr == WFD_ADDR_PAT_EN) rd_mux = {25'h0, pat_len};
    else if (rd_is_pat) rd_mux = pat_word;
    else begin
      rd_mux = 32'h00000000;
      rd_ok = 1'b0;
    end
  end
  // reads of status clear it and reads of interrupt clear its flag; set wins over the clear below
  wire rd_fire = rd_pend && !s_axi_rvalid;
  wire rd_clr_stat = rd_fire && rd_addr == WFD_ADDR_STAT;
  wire rd_clr_int = rd_fire && rd_addr == WFD_ADDR_INT;
  wire next_rd_pend = (s_axi_arvalid && s_axi_arready) || (rd_pend && s_axi_rvalid);
  wire next_rvalid = rd_fire || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_addr <= 12'h000;
      rd_pend <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= WFD_RESP_OK;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !next_rd_pend && !next_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_addr <= s_axi_araddr;
        rd_pend <= 1'b1;
      end else if (rd_fire) begin
        rd_pend <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? WFD_RESP_OK : WFD_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // user pattern memory, shared read port: scanner or bus
  // ---------------------------------------------------------------
  logic [5:0] byte_idx;
  // a bus read owns the port from its address edge on; a frame start points the scanner at word 0
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire bus_port = ar_take || rd_pend;
  wire [3:0] scan_rd_addr = (rx_byte_valid && rx_sof) ? 4'h0 : byte_idx[5:2];
  wire [3:0] pat_rd_addr = ar_take ? s_axi_araddr[5:2] : (rd_pend ? rd_addr[5:2] : scan_rd_addr);
  wfd_pat_mem #(.DEPTH(16)) u_pat_mem (
    .clock(clock),
    .wr_en(wr_pat),
    .wr_addr(aw_addr[5:2]),
    .wr_data(w_data),
    .wr_strb(w_strb),
    .rd_addr(pat_rd_addr),
    .rd_data(pat_word)
  );

  // ---------------------------------------------------------------
  // checksum over the whole frame including fcs
  // ---------------------------------------------------------------
  function automatic logic [31:0] wfd_crc8(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
    end
    return c;
  endfunction : wfd_crc8

  logic [31:0] crc;
  wire [31:0] next_crc = wfd_crc8(rx_sof ? 32'hffffffff : crc, rx_byte);

  // ---------------------------------------------------------------
  // frame scanner
  // ---------------------------------------------------------------
  wfd_scan_t state;
  logic [2:0] sync_cnt;
  logic [2:0] addr_pos;
  logic [4:0] rep_cnt;
  logic [10:0] frame_pos;
  logic da_own;
  logic da_bcast;
  logic magic_hit;
  logic pw_hit;
  logic pat_ok;
  wire in_byte = rx_byte_valid;
  // pattern data lags one byte behind; the compare uses the byte delayed to match
  logic [7:0] prev_byte;
  logic prev_valid;
  logic [5:0] prev_idx;
  wire [7:0] pat_byte = pat_word[8*prev_idx[1:0] +: 8];

  wire [7:0] own_byte = station_addr[8*addr_pos +: 8];
  wire [7:0] pw_byte = password[8*addr_pos +: 8];
  wire addressed = da_own || (da_bcast && wake_config_reg[WFD_CFG_BCAST_EN]);
  wire in_da = frame_pos < 11'(WFD_ADDR_BYTES);
  wire da_ok_now = in_da || addressed;
  wire last_addr = addr_pos == 3'(WFD_ADDR_BYTES - 1);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= WFD_SYNC;
      sync_cnt <= 3'h0;
      addr_pos <= 3'h0;
      rep_cnt <= 5'h00;
      frame_pos <= 11'h000;
      da_own <= 1'b0;
      da_bcast <= 1'b0;
      magic_hit <= 1'b0;
      pw_hit <= 1'b0;
      crc <= 32'h00000000;
    end else if (in_byte) begin
      crc <= next_crc;
      frame_pos <= rx_sof ? 11'h001 : (frame_pos == 11'h7ff ? frame_pos : frame_pos + 11'h001);
      if (rx_sof) begin
        da_own <= rx_byte == station_addr[7:0];
        da_bcast <= rx_byte == 8'hff;
        magic_hit <= 1'b0;
        pw_hit <= 1'b0;
      end else if (in_da) begin
        da_own <= da_own && rx_byte == station_addr[8*frame_pos[2:0] +: 8];
        da_bcast <= da_bcast && rx_byte == 8'hff;
      end
      // sync counter runs at any position, so the sequence can start anywhere
      if (rx_sof || state != WFD_SYNC) begin
        sync_cnt <= (!rx_sof && rx_byte == WFD_SYNC_BYTE) ? 3'h1 : 3'h0;
      end else if (rx_byte == WFD_SYNC_BYTE) begin
        sync_cnt <= (sync_cnt == 3'(WFD_SYNC_LEN)) ? sync_cnt : sync_cnt + 3'h1;
      end else begin
        sync_cnt <= 3'h0;
      end
      case (state)
        WFD_SYNC: begin
          // six ff seen; a matching first address byte starts the repetitions
          if (!rx_sof && sync_cnt == 3'(WFD_SYNC_LEN) && rx_byte == own_byte && da_ok_now) begin
            state <= WFD_REPEAT;
            addr_pos <= 3'h1;
            rep_cnt <= 5'h00;
          end else begin
            addr_pos <= 3'h0;
          end
        end
        WFD_REPEAT: begin
          if (rx_sof || rx_byte != own_byte || !da_ok_now) begin
            // a mismatch drops back to sync; an ff byte here restarts the sync count at one
            state <= WFD_SYNC;
            addr_pos <= 3'h0;
          end else if (last_addr) begin
            addr_pos <= 3'h0;
            if (rep_cnt == 5'(WFD_REPEATS - 1)) begin
              if (wake_config_reg[WFD_CFG_PW_EN]) state <= WFD_PASSWORD;
              else begin
                state <= WFD_DONE;
                magic_hit <= 1'b1;
              end
            end
            rep_cnt <= rep_cnt + 5'h01;
          end else begin
            addr_pos <= addr_pos + 3'h1;
          end
        end
        WFD_PASSWORD: begin
          if (rx_sof || rx_byte != pw_byte) begin
            state <= WFD_SYNC;
            addr_pos <= 3'h0;
          end else if (last_addr) begin
            state <= WFD_DONE;
            pw_hit <= 1'b1;
            addr_pos <= 3'h0;
          end else begin
            addr_pos <= addr_pos + 3'h1;
          end
        end
        WFD_DONE: begin
          if (rx_sof) state <= WFD_SYNC;
        end
        default: state <= WFD_SYNC;
      endcase
    end
  end

  // user pattern compare on the first pat_len bytes of the frame
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      byte_idx <= 6'h00;
      prev_byte <= 8'h00;
      prev_valid <= 1'b0;
      prev_idx <= 6'h00;
      pat_ok <= 1'b0;
    end else begin
      prev_valid <= in_byte && !bus_port && (rx_sof || (frame_pos != 11'h000 && frame_pos < 11'(WFD_PAT_BYTES)));
      prev_byte <= rx_byte;
      prev_idx <= rx_sof ? 6'h00 : byte_idx;
      if (in_byte) begin
        byte_idx <= rx_sof ? 6'h01 : byte_idx + 6'h01;
        if (rx_sof) pat_ok <= !bus_port;
        else if (bus_port && frame_pos < 11'(WFD_PAT_BYTES)) pat_ok <= 1'b0; // bus read stole the port
      end
      if (prev_valid && 7'(prev_idx) < pat_len && pat_byte != prev_byte) pat_ok <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // end of frame: checksum gate, status, interrupt, wake pin
  // ---------------------------------------------------------------
  wire crc_good = next_crc == WFD_CRC_RESIDUE;
  wire eof_now = in_byte && rx_eof;
  wire en_wake = wake_config_reg[WFD_CFG_WAKE_EN];
  wire pat_hit = wake_config_reg[WFD_CFG_PAT_EN] && pat_ok && pat_len != 7'h00 && frame_pos >= 11'(pat_len) - 11'h001;
  wire hit_magic = en_wake && (magic_hit || pw_hit) && !wake_config_reg[WFD_CFG_PW_EN];
  wire hit_pw = en_wake && pw_hit;
  // pending match decided only on the last byte once the fcs is known
  wire any_hit = eof_now && crc_good && (hit_magic || hit_pw || pat_hit);
  wire crc_reject = eof_now && !crc_good && (hit_magic || hit_pw || pat_hit);
  logic [3:0] pulse_cnt;

  // sticky status and flag; a new event beats a read-clear in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wake_status_reg <= 4'h0;
      int_flag <= 1'b0;
      wake_irq <= 1'b0;
    end else begin
      wake_status_reg <= (rd_clr_stat ? 4'h0 : wake_status_reg)
        | {crc_reject, any_hit && pat_hit, any_hit && hit_pw, any_hit && hit_magic};
      if (any_hit) int_flag <= 1'b1;
      else if (rd_clr_int || (wr_stat && w_strb[0] && w_data[WFD_INT_FLAG])) int_flag <= 1'b0;
      wake_irq <= (any_hit || int_flag) && int_en;
    end
  end

  // wake pin: level stays until the flag clears, pulse lasts a fixed count
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pulse_cnt <= 4'h0;
      wake_pin <= 1'b0;
    end else begin
      if (any_hit) pulse_cnt <= 4'(WFD_PULSE_CYCLES);
      else if (pulse_cnt != 4'h0) pulse_cnt <= pulse_cnt - 4'h1;
      wake_pin <= wake_config_reg[WFD_CFG_PIN_LEVEL] ? (any_hit || int_flag) : (any_hit || pulse_cnt > 4'h1);
    end
  end
endmodule : wfd_wake_frame_detect

// File: wfd_pkg.sv
// wfd_pkg.sv: register map, field positions and constants of the wake frame detector
package wfd_pkg;
  // ---------------------------------------------------------------
  // register byte addresses (bus side)
  // ---------------------------------------------------------------
  localparam logic [11:0] WFD_ADDR_CFG = 12'h000; // wake_config_reg
  localparam logic [11:0] WFD_ADDR_STAT = 12'h004; // wake_status_reg
  localparam logic [11:0] WFD_ADDR_INT = 12'h008; // interrupt_status_two
  localparam logic [11:0] WFD_ADDR_MAC_LO = 12'h00c; // station address bytes 0..3
  localparam logic [11:0] WFD_ADDR_MAC_HI = 12'h010; // station address bytes 4..5
  localparam logic [11:0] WFD_ADDR_PW_LO = 12'h014; // password bytes 0..3
  localparam logic [11:0] WFD_ADDR_PW_HI = 12'h018; // password bytes 4..5
  localparam logic [11:0] WFD_ADDR_PAT_EN = 12'h01c; // user pattern compare enable length
  localparam logic [11:0] WFD_ADDR_PAT_BASE = 12'h100; // 16 words of user pattern
  // ---------------------------------------------------------------
  // config fields
  // ---------------------------------------------------------------
  localparam int WFD_CFG_WAKE_EN = 0;
  localparam int WFD_CFG_PW_EN = 1;
  localparam int WFD_CFG_PAT_EN = 2;
  localparam int WFD_CFG_BCAST_EN = 3;
  localparam int WFD_CFG_PIN_LEVEL = 4;
  localparam int WFD_CFG_W = 5;
  localparam logic [WFD_CFG_W-1:0] WFD_CFG_RST = 5'h09;
  // status bits
  localparam int WFD_ST_MAGIC = 0;
  localparam int WFD_ST_PW = 1;
  localparam int WFD_ST_PAT = 2;
  localparam int WFD_ST_CRC_BAD = 3;
  localparam int WFD_ST_W = 4;
  // interrupt register: bit0 flag, bit1 enable
  localparam int WFD_INT_FLAG = 0;
  localparam int WFD_INT_EN = 1;
  // ---------------------------------------------------------------
  // frame constants
  // ---------------------------------------------------------------
  localparam int WFD_SYNC_LEN = 6;
  localparam int WFD_REPEATS = 16;
  localparam int WFD_ADDR_BYTES = 6;
  localparam int WFD_PAT_BYTES = 64;
  localparam logic [7:0] WFD_SYNC_BYTE = 8'hff;
  localparam logic [31:0] WFD_CRC_RESIDUE = 32'hdebb20e3; // lsb-first register, not inverted
  localparam int WFD_PULSE_CYCLES = 8;
  // axi responses
  localparam logic [1:0] WFD_RESP_OK = 2'h0;
  localparam logic [1:0] WFD_RESP_SLVERR = 2'h2;
  // scan states
  typedef enum logic [1:0] {WFD_SYNC, WFD_REPEAT, WFD_PASSWORD, WFD_DONE} wfd_scan_t;
endpackage : wfd_pkg

// File: wfd_pat_mem.sv
// wfd_pat_mem.sv: user pattern store, written by software, read a word at a time by the scanner
`timescale 1ns/1ps
module wfd_pat_mem #(
  parameter int DEPTH = 16
) (
  // clock
  input wire logic clock,
  // word write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  // word read port, registered
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [31:0] rd_data
);
  logic [31:0] mem [DEPTH];
  // byte-lane write, registered read; no reset so it maps to ram
  always_ff @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (wr_en && wr_strb[i]) begin
        mem[wr_addr][8*i +: 8] <= wr_data[8*i +: 8];
      end
    end
    rd_data <= mem[rd_addr];
  end
endmodule : wfd_pat_mem

// File: wfd_checker_sva.sv
// wfd_checker_sva.sv: bus and wake timing assertions for the wake frame detector
`timescale 1ns/1ps
module wfd_checker
  import wfd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // receive stream
  input wire logic rx_byte_valid,
  input wire logic rx_eof,
  // bus write side
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // bus read side
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // notification
  input wire logic wake_pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // handshake steps
  // ---------------------------------------------------------------
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (rd_take |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read answer not two cycles after address");
  chk_bad_write: assert property (wr_both ##0 (s_axi_awaddr inside {[12'h020:12'h0fc]})
    |-> ##2 s_axi_bresp == WFD_RESP_SLVERR) else $error("unmapped write not refused");
  chk_bad_read: assert property (rd_take ##0 (s_axi_araddr inside {[12'h020:12'h0fc]})
    |-> ##2 (s_axi_rresp == WFD_RESP_SLVERR && s_axi_rdata == 32'h0)) else $error("unmapped read not refused");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_ready_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken while answer pending");
  chk_wake_eof: assert property ($rose(wake_pin) |-> $past(rx_byte_valid && rx_eof, 1))
    else $error("wake pin rose away from frame end");
endmodule : wfd_checker

bind wfd_wake_frame_detect wfd_checker chk_u (.*);

// File: wfd_host_model.sv
// wfd_host_model.sv: host controller that counts wake pulses and their length
`timescale 1ns/1ps
module wfd_host_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // wake notification
  input wire logic wake_pin,
  // observations
  output logic [7:0] pulse_len,
  output logic [7:0] wake_count
);
  logic [7:0] run;
  // a wake is counted when the pin falls, so a level counts only once the flag clears and the pin drops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run <= 8'h00;
      pulse_len <= 8'h00;
      wake_count <= 8'h00;
    end else if (wake_pin) begin
      run <= run + 8'h01;
    end else begin
      if (run != 8'h00) begin
        pulse_len <= run;
        wake_count <= wake_count + 8'h01;
      end
      run <= 8'h00;
    end
  end
endmodule : wfd_host_model

// File: test_wake_frame_detector.sv
// test_wake_frame_detector.sv: register and wake frame tests for the wake frame detector
`timescale 1ns/1ps
module test_wake_frame_detector;
  import wfd_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clock, rst_b, rx_sof, rx_byte_valid, rx_eof, wake_pin, wake_irq, lvl;
  logic [7:0] rx_byte, pulse_len, wake_count;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] mac[6] = '{8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
  logic [7:0] pwd[6] = '{8'h2a, 8'h3b, 8'h4c, 8'h5d, 8'h6e, 8'h7f};
  int fail_count = 0, samples_checked = 0, cycles = 0, wakes = 0;
  wfd_wake_frame_detect dut_u (.*);
  wfd_host_model host_u (.*);
  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // ready and answers sampled at the falling edge, settled for the next rising one; bready and rready stay high
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    bit ha, hw, hb;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
    do begin
      @(negedge clock);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      {hb, rs} = {s_axi_bvalid, s_axi_bresp};
      @(posedge clock);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!hb);
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a);
    bit h;
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do begin
      @(negedge clock);
      h = s_axi_arready;
      @(posedge clock);
    end while (!h);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clock);
      {h, rd, rs} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clock);
    end while (!h);
  endtask : axi_rd
  function automatic logic [31:0] fcs(input logic [7:0] f[$]);
    logic [31:0] c = '1;
    foreach (f[i]) for (int b = 0; b < 8; b++) c = (c >> 1) ^ ((c[0] ^ f[i][b]) ? 32'hedb88320 : 32'h0);
    return ~c;
  endfunction : fcs
  // builds address, sync run, repeats, optional password, padding and checksum
  task automatic run_frame(input bit bc, od, pw, cr, input int ns, nr, input logic [3:0] es);
    logic [7:0] f[$];
    logic [31:0] c;
    logic h;
    for (int k = 0; k < 6; k++) f.push_back(bc ? 8'hff : (od ? 8'h0e : mac[k]));
    for (int k = 0; k < 8; k++) f.push_back(8'h20 + 8'(k));
    repeat (ns) f.push_back(8'hff);
    repeat (nr) foreach (mac[k]) f.push_back(mac[k]);
    if (pw) foreach (pwd[k]) f.push_back(pwd[k]);
    repeat (20) f.push_back(8'h00);
    c = fcs(f) ^ {31'h0, !cr};
    for (int k = 0; k < 4; k++) f.push_back(c[8*k +: 8]);
    foreach (f[k]) begin
      {rx_sof, rx_eof, rx_byte, rx_byte_valid} <= {k == 0, k == f.size() - 1, f[k], 1'b1};
      @(posedge clock);
    end
    {rx_sof, rx_eof, rx_byte_valid} <= 3'h0;
    repeat (16) @(posedge clock);
    h = |es[2:0];
    chk("irq", wake_irq, h);
    if (lvl) chk("pin level", wake_pin, h);
    if (h && !lvl) wakes++;
    chk("wake count", wake_count, wakes);
    if (h && !lvl) chk("pulse", pulse_len, 8);
    axi_rd(WFD_ADDR_STAT);
    chk("status", rd, es);
    axi_rd(WFD_ADDR_INT);
    chk("int reg", rd, {1'b1, h});
    $display("frame test done");
  endtask : run_frame
  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_b, rx_sof, rx_byte_valid, rx_eof, rx_byte, s_axi_awaddr, s_axi_araddr, s_axi_wdata, lvl} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b00101;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    axi_rd(WFD_ADDR_CFG);
    chk("cfg reset", rd, 32'h9);
    axi_rd(12'h020);
    chk("unmapped read", rs, WFD_RESP_SLVERR);
    axi_wr(12'h020, 32'h1);
    chk("unmapped write", rs, WFD_RESP_SLVERR);
    axi_wr(WFD_ADDR_MAC_LO, {mac[3], mac[2], mac[1], mac[0]});
    axi_wr(WFD_ADDR_MAC_HI, {16'h0, mac[5], mac[4]});
    axi_wr(WFD_ADDR_PW_LO, {pwd[3], pwd[2], pwd[1], pwd[0]});
    axi_wr(WFD_ADDR_PW_HI, {16'h0, pwd[5], pwd[4]});
    axi_rd(WFD_ADDR_MAC_HI);
    chk("addr hi", rd, {16'h0, mac[5], mac[4]});
    axi_wr(WFD_ADDR_INT, 32'h2);
    $display("register test done");
    run_frame(0, 0, 0, 1, 6, 16, 4'h1);
    run_frame(1, 0, 0, 1, 6, 16, 4'h1);
    run_frame(0, 1, 0, 1, 6, 16, 4'h0);
    run_frame(0, 0, 0, 1, 6, 15, 4'h0);
    run_frame(0, 0, 0, 1, 5, 16, 4'h0);
    run_frame(0, 0, 0, 0, 6, 16, 4'h8);
    axi_wr(WFD_ADDR_CFG, 32'h0b);
    run_frame(0, 0, 1, 1, 6, 16, 4'h2);
    run_frame(0, 0, 0, 1, 6, 16, 4'h0);
    // user pattern: destination address then two header bytes
    axi_wr(WFD_ADDR_PAT_BASE, {mac[3], mac[2], mac[1], mac[0]});
    axi_wr(WFD_ADDR_PAT_BASE + 12'h004, {8'h21, 8'h20, mac[5], mac[4]});
    axi_wr(WFD_ADDR_PAT_EN, 32'h8);
    axi_rd(WFD_ADDR_PAT_BASE + 12'h004);
    chk("pattern word", rd, {8'h21, 8'h20, mac[5], mac[4]});
    axi_wr(WFD_ADDR_CFG, 32'h04);
    run_frame(0, 0, 0, 1, 6, 16, 4'h4);
    run_frame(0, 1, 0, 1, 6, 16, 4'h0);
    axi_wr(WFD_ADDR_CFG, 32'h19);
    lvl = 1'b1;
    run_frame(0, 0, 0, 1, 6, 16, 4'h1);
    summarize();
  end
endmodule : test_wake_frame_detector
